// ---- hdl/btsu_pkg.sv ----
// Package of constants and types for the bit test and set unit.
package btsu_pkg;

  // ***************************************************************
  // Opcode bytes and fields.
  // ***************************************************************
  localparam logic [7:0] PFX_CB   = 8'hcb;
  localparam logic [7:0] PFX_DD   = 8'hdd;
  localparam logic [7:0] PFX_FD   = 8'hfd;
  localparam logic [1:0] GRP_TEST = 2'h1;
  localparam logic [1:0] GRP_SET  = 2'h3;
  localparam logic [2:0] CODE_MEM = 3'h6;
  localparam logic [2:0] CODE_H   = 3'h4;
  localparam logic [2:0] CODE_L   = 3'h5;

  // ***************************************************************
  // Flag positions.
  // ***************************************************************
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;

  // ***************************************************************
  // Timing.
  // ***************************************************************
  localparam int         CLK_MHZ    = 100;
  localparam int         TSTATE_NS  = 250;
  localparam int         TSTATE_CYC = (TSTATE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] DIV_LAST   = 5'(TSTATE_CYC - 1);
  localparam logic [2:0] LEN_FETCH  = 3'h4;
  localparam logic [2:0] LEN_DISP   = 3'h3;
  localparam logic [2:0] LEN_OPRD   = 3'h5;
  localparam logic [2:0] LEN_MREAD  = 3'h4;
  localparam logic [2:0] LEN_MWRITE = 3'h3;

  // ***************************************************************
  // Register map, fields and reset values.
  // ***************************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PC     = 8'h08;
  localparam logic [7:0]  ADDR_FLAGS  = 8'h0c;
  localparam logic [7:0]  ADDR_IDX_X  = 8'h10;
  localparam logic [7:0]  ADDR_IDX_Y  = 8'h14;
  localparam logic [7:0]  ADDR_TIMING = 8'h18;
  localparam logic [7:0]  ADDR_BANK   = 8'h20;
  localparam int          CTRL_START  = 0;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_DONE     = 1;
  localparam int          ST_ERR      = 2;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  localparam logic [15:0] IDX_RST     = 16'h0000;
  localparam logic [7:0]  BANK_RST    = 8'h00;

  typedef enum logic [2:0] {PH_IDLE, PH_FETCH, PH_DISP, PH_OPRD, PH_MREAD, PH_MWRITE} btsu_phase_t;
  typedef enum logic [1:0] {IX_NONE, IX_X, IX_Y} btsu_idx_t;

endpackage : btsu_pkg

// ---- hdl/btsu_bank_if.sv ----
// Interface between the engine and its byte register bank.
`timescale 1ns/1ps
interface btsu_bank_if;
  logic [2:0]  core_code;
  logic [7:0]  core_data;
  logic [2:0]  bus_code;
  logic [7:0]  bus_data;
  logic        wr_en;
  logic [2:0]  wr_code;
  logic [7:0]  wr_data;
  logic [15:0] pair;

  modport bank (input core_code, bus_code, wr_en, wr_code, wr_data, output core_data, bus_data, pair);
  modport user (output core_code, bus_code, wr_en, wr_code, wr_data, input core_data, bus_data, pair);
endinterface : btsu_bank_if

// ---- hdl/btsu_reg_bank.sv ----
// Bank of seven byte registers addressed by the register field.
`timescale 1ns/1ps
module btsu_reg_bank (
  input  wire logic i_clock,
  input  wire logic i_rst,
  btsu_bank_if.bank bif
);

  typedef struct packed {
    logic [7:0][7:0] ent;
  } btsu_bank_state_t;

  btsu_bank_state_t st_r;
  btsu_bank_state_t st_nxt;

  // ***************************************************************
  // Write port; code 110 holds no register and stays zero.
  // ***************************************************************
  always_comb
  begin
    st_nxt = st_r;
    if (bif.wr_en && bif.wr_code != btsu_pkg::CODE_MEM) // RULE2
    begin
      st_nxt.ent[bif.wr_code] = bif.wr_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '{ent: {8{btsu_pkg::BANK_RST}}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bif.core_data = st_r.ent[bif.core_code];
  assign bif.bus_data  = st_r.ent[bif.bus_code];
  assign bif.pair      = {st_r.ent[btsu_pkg::CODE_H], st_r.ent[btsu_pkg::CODE_L]};

endmodule : btsu_reg_bank

// ---- hdl/btsu_top.sv ----
// Bit test and bit set instruction engine with an APB register port.
`timescale 1ns/1ps
// Functional notes
// RULE1: Prefix, then 01, bit, register decodes test.
// RULE2: Register codes 000-101, 111; 110 means memory.
// RULE3: Bit field 000-111 selects bits 0 to 7.
// RULE4: Test: zero flag inverted bit, H set, N clear.
// RULE5: A test never writes its operand.
// RULE6: Prefix, 01 bit 110 tests pointer pair byte.
// RULE7: Test at first index plus signed displacement.
// RULE8: Test at second index plus signed displacement.
// RULE9: Register set forces bit, keeps all flags.
// RULE10: Pointer pair set reads, sets, writes back.
// RULE11: First index set reads, sets, writes back.
// RULE12: First index set: 6 M, 23 T.
// RULE13: Second index set uses second index address.
// RULE14: Register forms 8 T; indexed test 20 T.
// RULE15: Memory set forms end 11, bit, 110.
module btsu_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic             o_mem_fetch,
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [7:0]  i_mem_rdata
);

  typedef struct packed {
    btsu_pkg::btsu_phase_t phase;
    btsu_pkg::btsu_idx_t   idx;
    logic                  got_cb;
    logic [7:0]            opcode;
    logic [7:0]            disp;
    logic [7:0]            data;
    logic [15:0]           pc;
    logic [7:0]            flags;
    logic [15:0]           ix;
    logic [15:0]           iy;
    logic [4:0]            div;
    logic [2:0]            tcnt;
    logic                  acc_done;
    logic [2:0]            mcnt;
    logic [4:0]            ttot;
    logic [2:0]            last_m;
    logic [4:0]            last_t;
    logic                  done;
    logic                  err;
    logic                  mem_req;
    logic                  mem_we;
    logic [15:0]           mem_addr;
    logic [7:0]            mem_wdata;
    logic [31:0]           prdata;
    logic                  pslverr;
  } btsu_state_t;

  btsu_state_t st_r;
  btsu_state_t st_nxt;
  logic [2:0]  len;
  logic        busy;
  logic        tick;
  logic        m_end;
  logic        grp_ok;
  logic        sel_bit;
  logic        core_wr;
  logic        wr_bus;
  logic        fin;
  logic        fail;
  logic [7:0]  b;
  logic [7:0]  dec;
  logic [7:0]  operand;
  logic [7:0]  mask;
  logic [15:0] sext;
  logic [15:0] ea;

  btsu_bank_if bif ();

  btsu_reg_bank u_bank (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bif     (bif.bank)
  );

  // ***************************************************************
  // Machine cycle length and start of a machine cycle.
  // ***************************************************************
  function automatic logic [2:0] m_len(input btsu_pkg::btsu_phase_t ph);
    logic [2:0] n;
    n = btsu_pkg::LEN_FETCH;
    unique case (ph)
      btsu_pkg::PH_IDLE:   n = btsu_pkg::LEN_FETCH;
      btsu_pkg::PH_FETCH:  n = btsu_pkg::LEN_FETCH;
      btsu_pkg::PH_DISP:   n = btsu_pkg::LEN_DISP;
      btsu_pkg::PH_OPRD:   n = btsu_pkg::LEN_OPRD;
      btsu_pkg::PH_MREAD:  n = btsu_pkg::LEN_MREAD;
      btsu_pkg::PH_MWRITE: n = btsu_pkg::LEN_MWRITE;
    endcase
    return n;
  endfunction : m_len

  function automatic btsu_state_t begin_m(input btsu_state_t s, input btsu_pkg::btsu_phase_t ph,
                                          input logic [15:0] a);
    btsu_state_t t;
    t          = s;
    t.phase    = ph;
    t.div      = 5'h00;
    t.tcnt     = 3'h0;
    t.acc_done = 1'h0;
    t.mem_req  = 1'h1;
    t.mem_we   = (ph == btsu_pkg::PH_MWRITE);
    t.mem_addr = a;
    return t;
  endfunction : begin_m

  // ***************************************************************
  // Decode helpers.
  // ***************************************************************
  assign busy    = st_r.phase != btsu_pkg::PH_IDLE;
  assign tick    = st_r.div == btsu_pkg::DIV_LAST;
  assign len     = m_len(st_r.phase);
  assign m_end   = busy && tick && st_r.tcnt == len - 3'h1 && st_r.acc_done;
  assign b       = st_r.data;
  assign dec     = (st_r.phase == btsu_pkg::PH_FETCH) ? b : st_r.opcode;
  assign grp_ok  = dec[7:6] == btsu_pkg::GRP_TEST || dec[7:6] == btsu_pkg::GRP_SET; // RULE1
  assign operand = (st_r.phase == btsu_pkg::PH_MREAD) ? b : bif.core_data;
  assign sel_bit = operand[dec[5:3]]; // RULE3
  assign mask    = 8'h01 << dec[5:3]; // RULE3
  assign sext    = {{8{st_r.disp[7]}}, st_r.disp};
  assign ea      = ((st_r.idx == btsu_pkg::IX_X) ? st_r.ix : st_r.iy) + sext; // RULE7 RULE8 RULE11 RULE13

  assign core_wr = m_end && st_r.phase == btsu_pkg::PH_FETCH && st_r.got_cb
                   && dec[7:6] == btsu_pkg::GRP_SET && dec[2:0] != btsu_pkg::CODE_MEM; // RULE9 RULE5
  assign wr_bus  = i_psel && i_penable && i_pwrite && !busy && !st_r.pslverr
                   && i_paddr[7:5] == btsu_pkg::ADDR_BANK[7:5];

  assign bif.core_code = dec[2:0];
  assign bif.bus_code  = i_paddr[4:2];
  assign bif.wr_en     = core_wr || wr_bus;
  assign bif.wr_code   = core_wr ? dec[2:0] : i_paddr[4:2];
  assign bif.wr_data   = core_wr ? (bif.core_data | mask) : i_pwdata[7:0]; // RULE9

  // ***************************************************************
  // Bus slave and instruction sequencer.
  // ***************************************************************
  always_comb
  begin
    st_nxt = st_r;
    fin    = 1'h0;
    fail   = 1'h0;
    if (i_psel && !i_penable)
    begin
      st_nxt.pslverr = 1'h0;
      st_nxt.prdata  = 32'h0000_0000;
      case (i_paddr)
        btsu_pkg::ADDR_CTRL:   st_nxt.prdata[btsu_pkg::ST_BUSY] = busy;
        btsu_pkg::ADDR_STATUS:
        begin
          st_nxt.prdata[btsu_pkg::ST_BUSY] = busy;
          st_nxt.prdata[btsu_pkg::ST_DONE] = st_r.done;
          st_nxt.prdata[btsu_pkg::ST_ERR]  = st_r.err;
        end
        btsu_pkg::ADDR_PC:     st_nxt.prdata[15:0] = st_r.pc;
        btsu_pkg::ADDR_FLAGS:  st_nxt.prdata[7:0] = st_r.flags;
        btsu_pkg::ADDR_IDX_X:  st_nxt.prdata[15:0] = st_r.ix;
        btsu_pkg::ADDR_IDX_Y:  st_nxt.prdata[15:0] = st_r.iy;
        btsu_pkg::ADDR_TIMING: st_nxt.prdata[7:0] = {st_r.last_t, st_r.last_m};
        default:
        begin
          if (i_paddr[7:5] == btsu_pkg::ADDR_BANK[7:5] && i_paddr[1:0] == 2'h0)
          begin
            st_nxt.prdata[7:0] = bif.bus_data;
          end
          else
          begin
            st_nxt.pslverr = 1'h1;
          end
        end
      endcase
    end
    if (i_psel && i_penable && i_pwrite && !st_r.pslverr)
    begin
      if (i_paddr == btsu_pkg::ADDR_STATUS)
      begin
        if (i_pwdata[btsu_pkg::ST_DONE])
        begin
          st_nxt.done = 1'h0;
        end
        if (i_pwdata[btsu_pkg::ST_ERR])
        begin
          st_nxt.err = 1'h0;
        end
      end
      if (!busy)
      begin
        case (i_paddr)
          btsu_pkg::ADDR_CTRL:
          begin
            if (i_pwdata[btsu_pkg::CTRL_START])
            begin
              st_nxt.idx    = btsu_pkg::IX_NONE;
              st_nxt.got_cb = 1'h0;
              st_nxt.mcnt   = 3'h0;
              st_nxt.ttot   = 5'h00;
              st_nxt        = begin_m(st_nxt, btsu_pkg::PH_FETCH, st_r.pc);
            end
          end
          btsu_pkg::ADDR_PC:    st_nxt.pc = i_pwdata[15:0];
          btsu_pkg::ADDR_FLAGS: st_nxt.flags = i_pwdata[7:0];
          btsu_pkg::ADDR_IDX_X: st_nxt.ix = i_pwdata[15:0];
          btsu_pkg::ADDR_IDX_Y: st_nxt.iy = i_pwdata[15:0];
          default:              st_nxt.pc = st_r.pc;
        endcase
      end
    end
    if (busy)
    begin
      st_nxt.div = tick ? 5'h00 : st_r.div + 5'h01;
      if (tick && st_r.tcnt != len - 3'h1)
      begin
        st_nxt.tcnt = st_r.tcnt + 3'h1;
      end
      if (st_r.mem_req && i_mem_ack)
      begin
        st_nxt.mem_req  = 1'h0;
        st_nxt.acc_done = 1'h1;
        if (!st_r.mem_we)
        begin
          st_nxt.data = i_mem_rdata;
        end
      end
      if (m_end)
      begin
        st_nxt.mcnt = st_r.mcnt + 3'h1;
        st_nxt.ttot = st_r.ttot + {2'h0, len}; // RULE12 RULE14
        unique case (st_r.phase)
          btsu_pkg::PH_IDLE: fail = 1'h1;
          btsu_pkg::PH_FETCH:
          begin
            st_nxt.pc = st_r.pc + 16'h0001;
            if (!st_r.got_cb)
            begin
              if (b == btsu_pkg::PFX_CB) // RULE1
              begin
                st_nxt.got_cb = 1'h1;
                st_nxt = begin_m(st_nxt, (st_r.idx == btsu_pkg::IX_NONE) ? btsu_pkg::PH_FETCH
                                                                         : btsu_pkg::PH_DISP, st_nxt.pc);
              end
              else if (st_r.idx == btsu_pkg::IX_NONE && b == btsu_pkg::PFX_DD) // RULE7
              begin
                st_nxt.idx = btsu_pkg::IX_X;
                st_nxt     = begin_m(st_nxt, btsu_pkg::PH_FETCH, st_nxt.pc);
              end
              else if (st_r.idx == btsu_pkg::IX_NONE && b == btsu_pkg::PFX_FD) // RULE8
              begin
                st_nxt.idx = btsu_pkg::IX_Y;
                st_nxt     = begin_m(st_nxt, btsu_pkg::PH_FETCH, st_nxt.pc);
              end
              else
              begin
                fail = 1'h1;
              end
            end
            else
            begin
              st_nxt.opcode = b;
              if (!grp_ok)
              begin
                fail = 1'h1;
              end
              else if (b[2:0] != btsu_pkg::CODE_MEM) // RULE2
              begin
                if (b[7:6] == btsu_pkg::GRP_TEST) // RULE4
                begin
                  st_nxt.flags[btsu_pkg::FLAG_Z] = !sel_bit;
                  st_nxt.flags[btsu_pkg::FLAG_H] = 1'h1;
                  st_nxt.flags[btsu_pkg::FLAG_N] = 1'h0;
                end
                fin = 1'h1;
              end
              else
              begin
                st_nxt = begin_m(st_nxt, btsu_pkg::PH_MREAD, bif.pair); // RULE6 RULE10
              end
            end
          end
          btsu_pkg::PH_DISP:
          begin
            st_nxt.disp = b;
            st_nxt.pc   = st_r.pc + 16'h0001;
            st_nxt      = begin_m(st_nxt, btsu_pkg::PH_OPRD, st_nxt.pc);
          end
          btsu_pkg::PH_OPRD:
          begin
            st_nxt.opcode = b;
            st_nxt.pc     = st_r.pc + 16'h0001;
            if (grp_ok && b[2:0] == btsu_pkg::CODE_MEM) // RULE15
            begin
              st_nxt = begin_m(st_nxt, btsu_pkg::PH_MREAD, ea); // RULE7 RULE8 RULE11 RULE13
            end
            else
            begin
              fail = 1'h1;
            end
          end
          btsu_pkg::PH_MREAD:
          begin
            if (st_r.opcode[7:6] == btsu_pkg::GRP_TEST) // RULE4 RULE5
            begin
              st_nxt.flags[btsu_pkg::FLAG_Z] = !sel_bit;
              st_nxt.flags[btsu_pkg::FLAG_H] = 1'h1;
              st_nxt.flags[btsu_pkg::FLAG_N] = 1'h0;
              fin = 1'h1;
            end
            else
            begin
              st_nxt.mem_wdata = b | mask; // RULE10 RULE11
              st_nxt           = begin_m(st_nxt, btsu_pkg::PH_MWRITE, st_r.mem_addr);
            end
          end
          btsu_pkg::PH_MWRITE: fin = 1'h1;
        endcase
        if (fin || fail)
        begin
          st_nxt.phase   = btsu_pkg::PH_IDLE;
          st_nxt.mem_req = 1'h0;
          st_nxt.last_m  = st_nxt.mcnt;
          st_nxt.last_t  = st_nxt.ttot;
          st_nxt.done    = st_nxt.done | fin;
          st_nxt.err     = st_nxt.err | fail;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r       <= '0;
      st_r.pc    <= btsu_pkg::PC_RST;
      st_r.flags <= btsu_pkg::FLAGS_RST;
      st_r.ix    <= btsu_pkg::IDX_RST;
      st_r.iy    <= btsu_pkg::IDX_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata    = st_r.prdata;
  assign o_pready    = i_psel && i_penable;
  assign o_pslverr   = i_psel && i_penable && st_r.pslverr;
  assign o_mem_req   = st_r.mem_req;
  assign o_mem_we    = st_r.mem_we;
  assign o_mem_fetch = st_r.mem_req && st_r.phase != btsu_pkg::PH_MREAD && st_r.phase != btsu_pkg::PH_MWRITE;
  assign o_mem_addr  = st_r.mem_addr;
  assign o_mem_wdata = st_r.mem_wdata;

  // ***************************************************************
  // Assertions.
  // ***************************************************************
  default clocking dclk @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic is_fetch_op;
  logic is_read_end;
  assign is_fetch_op = m_end && st_r.phase == btsu_pkg::PH_FETCH && st_r.got_cb;
  assign is_read_end = m_end && st_r.phase == btsu_pkg::PH_MREAD;

  a_reg_test_zero: assert property ( // RULE1
    is_fetch_op && b[7:6] == btsu_pkg::GRP_TEST && b[2:0] != btsu_pkg::CODE_MEM
    |=> !busy && st_r.flags[btsu_pkg::FLAG_Z] == !$past(bif.core_data[b[5:3]]))
    else $error("register bit test result wrong");
  a_mem_code_pair: assert property ( // RULE2 RULE6
    is_fetch_op && grp_ok && b[2:0] == btsu_pkg::CODE_MEM
    |=> st_r.phase == btsu_pkg::PH_MREAD && st_r.mem_addr == $past(bif.pair) && st_r.mem_req)
    else $error("memory form did not read pointer pair byte");
  a_mem_bit_pick: assert property ( // RULE3
    is_read_end && st_r.opcode[7:6] == btsu_pkg::GRP_TEST
    |=> st_r.flags[btsu_pkg::FLAG_Z] == !$past(st_r.data[st_r.opcode[5:3]]))
    else $error("wrong bit tested in memory byte");
  a_test_flag_set: assert property ( // RULE4
    is_read_end && st_r.opcode[7:6] == btsu_pkg::GRP_TEST
    |=> st_r.flags[btsu_pkg::FLAG_H] && !st_r.flags[btsu_pkg::FLAG_N]
        && st_r.flags[btsu_pkg::FLAG_C] == $past(st_r.flags[btsu_pkg::FLAG_C]))
    else $error("test flags wrong");
  a_test_no_mwrite: assert property ( // RULE5
    st_r.mem_req && st_r.mem_we |-> st_r.opcode[7:6] == btsu_pkg::GRP_SET)
    else $error("memory write during a test");
  a_test_no_rwrite: assert property ( // RULE5
    bif.wr_en && busy |-> st_r.phase == btsu_pkg::PH_FETCH && b[7:6] == btsu_pkg::GRP_SET)
    else $error("register write during a test");
  a_index_x_addr: assert property ( // RULE7 RULE11
    m_end && st_r.phase == btsu_pkg::PH_OPRD && st_r.idx == btsu_pkg::IX_X && grp_ok
    && b[2:0] == btsu_pkg::CODE_MEM
    |=> st_r.mem_addr == 16'($past(st_r.ix) + {{8{$past(st_r.disp[7])}}, $past(st_r.disp)}))
    else $error("first index address wrong");
  a_index_y_addr: assert property ( // RULE8 RULE13
    m_end && st_r.phase == btsu_pkg::PH_OPRD && st_r.idx == btsu_pkg::IX_Y && grp_ok
    && b[2:0] == btsu_pkg::CODE_MEM
    |=> st_r.mem_addr == 16'($past(st_r.iy) + {{8{$past(st_r.disp[7])}}, $past(st_r.disp)}))
    else $error("second index address wrong");
  a_reg_set_keep: assert property ( // RULE9
    core_wr |-> bif.wr_code == b[2:0] ##1 st_r.flags == $past(st_r.flags) && !busy)
    else $error("register set changed flags");
  a_set_writeback: assert property ( // RULE10
    is_read_end && st_r.opcode[7:6] == btsu_pkg::GRP_SET
    |=> st_r.phase == btsu_pkg::PH_MWRITE && st_r.mem_we && st_r.mem_addr == $past(st_r.mem_addr)
        && st_r.mem_wdata == ($past(st_r.data) | $past(mask)) && st_r.flags == $past(st_r.flags))
    else $error("set write back wrong");
  a_index_set_time: assert property ( // RULE12
    m_end && st_r.phase == btsu_pkg::PH_MWRITE && st_r.idx != btsu_pkg::IX_NONE
    |=> st_r.last_m == 3'h6 && st_r.last_t == 5'h17)
    else $error("indexed set timing wrong");
  a_short_op_time: assert property ( // RULE14
    is_fetch_op && grp_ok && b[2:0] != btsu_pkg::CODE_MEM |=> st_r.last_m == 3'h2 && st_r.last_t == 5'h08)
    else $error("register form timing wrong");
  a_index_test_time: assert property ( // RULE14
    is_read_end && st_r.idx != btsu_pkg::IX_NONE && st_r.opcode[7:6] == btsu_pkg::GRP_TEST
    |=> st_r.last_m == 3'h5 && st_r.last_t == 5'h14)
    else $error("indexed test timing wrong");
  a_set_mem_form: assert property ( // RULE15
    st_r.phase == btsu_pkg::PH_MWRITE |-> st_r.opcode[2:0] == btsu_pkg::CODE_MEM)
    else $error("memory set form wrong");

  c_reg_test: cover property (is_fetch_op && b[7:6] == btsu_pkg::GRP_TEST && b[2:0] != btsu_pkg::CODE_MEM);
  c_pair_set: cover property (m_end && st_r.phase == btsu_pkg::PH_MWRITE && st_r.idx == btsu_pkg::IX_NONE);
  c_index_set: cover property (m_end && st_r.phase == btsu_pkg::PH_MWRITE && st_r.idx == btsu_pkg::IX_Y);
  c_bad_code: cover property (m_end && fail);

endmodule : btsu_top

// ---- dv/btsu_mem_model.sv ----
// Memory model answering the engine's fetch, read and write cycles.
`timescale 1ns/1ps
module btsu_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic             o_ack,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] lag;
  initial
  begin
    o_ack   = 1'b0;
    o_rdata = 8'h00;
    lag     = 2'h0;
  end
  // Answers after a random lag; the data line toggles when not answering.
  always @(posedge i_clock)
  begin
    o_ack   <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack)
    begin
      lag <= lag - 2'h1;
      if (lag == 2'h0)
      begin
        o_ack   <= 1'b1;
        o_rdata <= mem[i_addr];
        lag     <= 2'($urandom);
        if (i_we)
          mem[i_addr] <= i_wdata;
      end
    end
  end
endmodule : btsu_mem_model

// ---- dv/testbench.sv ----
// Self-checking bench of the bit test and set engine.
`timescale 1ns/1ps
module testbench;
  logic        i_clock, i_rst, psel, pen, pwr, prdy, req, we, ack, perr, er, fe;
  logic [7:0]  paddr, wdata, rdata, v, f, d, op;
  logic [15:0] addr, base, ea;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, num_checks, k, b, r, nf, n0;
  btsu_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr), .o_mem_req(req),
    .o_mem_we(we), .o_mem_fetch(fe), .o_mem_addr(addr), .o_mem_wdata(wdata), .i_mem_ack(ack), .i_mem_rdata(rdata));
  btsu_mem_model memory (.i_clock(i_clock), .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata),
    .o_ack(ack), .o_rdata(rdata));
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= dt;
    @(posedge i_clock);
    pen <= 1'b1;
    do
      @(posedge i_clock);
    while (prdy !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge i_clock);
  endtask : apb
  // Counts instruction byte fetches completed on the memory side.
  always @(posedge i_clock)
    if (req && ack && fe)
      nf <= nf + 1;
  // Starts an instruction at address 100 and polls until done or error.
  task automatic launch();
    apb(1'b1, 8'h08, 32'h100);
    apb(1'b1, 8'h04, 32'h6);
    n0 = nf;
    apb(1'b1, 8'h00, 32'h1);
    rd = 32'h0;
    for (int n = 0; n < 300 && rd[2:1] === 2'b00; n++)
      apb(1'b0, 8'h04, 32'h0);
  endtask : launch
  function automatic logic [7:0] tm(input int kd);
    logic [4:0] t [6] = '{5'h08, 5'h08, 5'h0c, 5'h0f, 5'h14, 5'h17};
    return {t[kd], 3'(kd < 2 ? 2 : kd + 1)};
  endfunction : tm
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial
  begin
    #900000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {i_rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 43'h0};
    void'($urandom(32'h99136042));
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    apb(1'b1, 8'h38, 32'hff);
    apb(1'b0, 8'h38, 32'h0);
    check("code six", rd, 32'h0);
    check("code six error", 32'(er), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    for (int i = 0; i < 36; i++)
    begin
      k    = i % 6;
      b    = $urandom % 8;
      r    = $urandom % 7;
      r    = (r == 6) ? 7 : r;
      v    = 8'($urandom);
      f    = 8'($urandom);
      d    = 8'($urandom);
      base = {1'b1, 15'($urandom)};
      ea   = (k < 4) ? base : base + {{8{d[7]}}, d};
      op   = {(k % 2) ? 2'b11 : 2'b01, 3'(b), (k < 2) ? 3'(r) : 3'h6};
      memory.mem[16'h100] = (k < 4) ? 8'hcb : ((i / 6) % 2) ? 8'hfd : 8'hdd;
      memory.mem[16'h101] = (k < 4) ? op : 8'hcb;
      memory.mem[16'h102] = d;
      memory.mem[16'h103] = op;
      memory.mem[ea] = v;
      apb(1'b1, 8'h30, 32'(base[15:8]));
      apb(1'b1, 8'h34, 32'(base[7:0]));
      apb(1'b1, ((i / 6) % 2) ? 8'h14 : 8'h10, 32'(base));
      apb(1'b1, 8'(32 + 4 * r), (k < 2) ? 32'(v) : (r == 4) ? 32'(base[15:8]) : 32'(base[7:0]));
      apb(1'b1, 8'h0c, 32'(f));
      launch();
      check("status", rd, 32'h2);
      check("fetch count", nf - n0, (k < 4) ? 32'h2 : 32'h4);
      apb(1'b0, 8'h0c, 32'h0);
      check("flags", rd, 32'((k % 2) ? f : (f & 8'had) | {1'b0, ~v[b], 2'b01, 4'h0}));
      apb(1'b0, 8'(32 + 4 * r), 32'h0);
      check("operand", (k < 2) ? rd : 32'(memory.mem[ea]), 32'((k % 2) ? v | (8'h1 << b) : v));
      apb(1'b0, 8'h18, 32'h0);
      check("timing", rd, 32'(tm(k)));
      apb(1'b0, 8'h08, 32'h0);
      check("next pc", rd, (k < 4) ? 32'h102 : 32'h104);
    end
    memory.mem[16'h100] = 8'hcb;
    memory.mem[16'h101] = 8'h80;
    launch();
    check("bad opcode", rd, 32'h4);
    complete_run();
  end
endmodule : testbench
